// ---- hw/i2c_master_write_probe_seq.v ----
// i2c master sequencer: start, address and data shifting, ack, stop, restart
`timescale 1ns/1ps
`default_nettype none
`include "i2c_seq_map.vh"
module i2c_master_write_probe_seq (
  input wire core_clk,
  input wire reset_n,
  input wire block_on,
  input wire tx_irq_en,
  input wire start_set,
  input wire stop_set,
  input wire flush,
  input wire data_wr,
  input wire [7:0] data_in,
  output wire start_pending,
  output wire stop_pending,
  output wire tx_empty_flag,
  output wire nack_flag,
  output wire ack_status,
  output wire tx_irq,
  output wire nack_irq,
  output wire busy,
  input wire scl_in,
  output wire scl_out,
  output wire scl_oe,
  input wire sda_in,
  output wire sda_out,
  output wire sda_oe
);
  localparam [7:0] S_IDLE = 8'h01;
  localparam [7:0] S_START = 8'h02;
  localparam [7:0] S_BIT = 8'h04;
  localparam [7:0] S_WAIT = 8'h08;
  localparam [7:0] S_ACK = 8'h10;
  localparam [7:0] S_HOLD = 8'h20;
  localparam [7:0] S_STOP = 8'h40;

  // ==========================================
  // pin synchronisers
  reg [1:0] pin_m_q;
  reg [1:0] pin_s_q;
  wire scl_s;
  wire sda_s;

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_m_q <= 2'h3;
      pin_s_q <= 2'h3;
    end else begin
      pin_m_q <= {scl_in, sda_in};
      pin_s_q <= pin_m_q;
    end
  end
  assign scl_s = pin_s_q[1];
  assign sda_s = pin_s_q[0];

  // ==========================================
  // state
  reg [7:0] state_q;
  reg [7:0] state_d;
  reg [1:0] phase_q;
  reg [1:0] phase_d;
  reg [2:0] bitn_q;
  reg [2:0] bitn_d;
  reg [7:0] shift_q;
  reg [7:0] shift_d;
  reg [7:0] data_q;
  reg data_full_q;
  reg hide_q;
  reg start_q;
  reg stop_q;
  reg nack_q;
  reg ack_q;
  reg scl_low_q;
  reg sda_low_q;
  reg scl_low_d;
  reg sda_low_d;
  reg load;
  reg unhide;
  reg start_clr;
  reg stop_clr;
  reg nack_set;
  reg nack_clr;
  reg ack_upd;
  wire tick;
  wire more;

  // a released clock line that still reads low is a slave stretching it
  bit_timer u_timer (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .run(state_q != S_IDLE),
    .stall(~scl_low_q & ~scl_s),
    .tick(tick)
  );

  // next byte known, or the transfer ends here
  assign more = data_full_q | start_q | stop_q;

  // ==========================================
  // sequencing
  always @* begin
    state_d = state_q;
    phase_d = phase_q;
    bitn_d = bitn_q;
    shift_d = shift_q;
    load = 1'h0;
    unhide = 1'h0;
    start_clr = 1'h0;
    stop_clr = 1'h0;
    nack_set = 1'h0;
    nack_clr = 1'h0;
    ack_upd = 1'h0;
    case (state_q)
      S_IDLE: begin
        phase_d = `PH_SETUP;
        if (start_q && data_full_q) begin
          state_d = S_START;
        end
      end
      S_START: begin
        if (tick) begin
          if (phase_q == `PH_HIGH) begin
            state_d = S_BIT;
            phase_d = `PH_SETUP;
            bitn_d = `BIT_FIRST;
            shift_d = data_q;
            load = 1'h1;
            start_clr = 1'h1;
            nack_clr = 1'h1;
          end else begin
            phase_d = phase_q + 1'h1;
          end
        end
      end
      S_BIT: begin
        if (tick) begin
          if (phase_q == `PH_HIGH) begin
            phase_d = `PH_SETUP;
            shift_d = {shift_q[6:0], 1'h0};
            unhide = (bitn_q == `BIT_FIRST);
            if (bitn_q == `BIT_LAST) begin
              state_d = more ? S_ACK : S_WAIT;
            end else begin
              bitn_d = bitn_q + 1'h1;
            end
          end else begin
            phase_d = phase_q + 1'h1;
          end
        end
      end
      S_WAIT: begin
        phase_d = `PH_SETUP;
        if (more) begin
          state_d = S_ACK;
        end
      end
      S_ACK: begin
        if (tick) begin
          if (phase_q == `PH_RISE) begin
            ack_upd = 1'h1;
          end
          if (phase_q == `PH_HIGH) begin
            phase_d = `PH_SETUP;
            if (stop_q) begin
              state_d = S_STOP;
            end else if (start_q) begin
              state_d = S_HOLD;
            end else if (ack_q) begin
              state_d = S_BIT;
              bitn_d = `BIT_FIRST;
              shift_d = data_q;
              load = 1'h1;
            end else begin
              state_d = S_HOLD;
              nack_set = 1'h1;
            end
          end else begin
            phase_d = phase_q + 1'h1;
          end
        end
      end
      S_HOLD: begin
        phase_d = `PH_SETUP;
        if (stop_q) begin
          state_d = S_STOP;
        end else if (start_q) begin
          state_d = S_START;
        end
      end
      S_STOP: begin
        if (tick) begin
          if (phase_q == `PH_HIGH) begin
            state_d = S_IDLE;
            stop_clr = 1'h1;
            nack_clr = 1'h1;
          end else begin
            phase_d = phase_q + 1'h1;
          end
        end
      end
      default: begin
        state_d = S_IDLE;
        phase_d = `PH_SETUP;
      end
    endcase
    if (!block_on) begin
      state_d = S_IDLE;
      phase_d = `PH_SETUP;
    end
  end

  // ==========================================
  // line drive, open-drain pulls only
  // outside start and stop, data only moves in the low quarter, after the clock was already pulled low in the setup quarter
  always @* begin
    scl_low_d = 1'h0;
    sda_low_d = 1'h0;
    case (state_q)
      S_IDLE: begin
        scl_low_d = 1'h0;
        sda_low_d = 1'h0;
      end
      S_START: begin
        scl_low_d = (phase_q == `PH_RISE || phase_q == `PH_HIGH) ? 1'h0 : scl_low_q;
        sda_low_d = (phase_q == `PH_SETUP) ? sda_low_q : (phase_q == `PH_HIGH);
      end
      S_BIT: begin
        scl_low_d = (phase_q == `PH_SETUP || phase_q == `PH_LOW);
        sda_low_d = (phase_q == `PH_SETUP) ? sda_low_q : ~shift_q[7];
      end
      S_WAIT, S_HOLD: begin
        scl_low_d = 1'h1;
        sda_low_d = sda_low_q;
      end
      S_ACK: begin
        scl_low_d = (phase_q == `PH_SETUP || phase_q == `PH_LOW);
        sda_low_d = (phase_q == `PH_SETUP) ? sda_low_q : 1'h0;
      end
      S_STOP: begin
        scl_low_d = (phase_q == `PH_SETUP || phase_q == `PH_LOW);
        sda_low_d = (phase_q == `PH_SETUP) ? sda_low_q : (phase_q != `PH_HIGH);
      end
      default: begin
        scl_low_d = 1'h0;
        sda_low_d = 1'h0;
      end
    endcase
  end

  // ==========================================
  // registers
  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= S_IDLE;
      phase_q <= `PH_SETUP;
      bitn_q <= `BIT_FIRST;
      shift_q <= `BYTE_RST;
      data_q <= `BYTE_RST;
      data_full_q <= 1'h0;
      hide_q <= 1'h0;
      start_q <= 1'h0;
      stop_q <= 1'h0;
      nack_q <= 1'h0;
      ack_q <= 1'h0;
      scl_low_q <= 1'h0;
      sda_low_q <= 1'h0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      bitn_q <= bitn_d;
      shift_q <= shift_d;
      scl_low_q <= scl_low_d;
      sda_low_q <= sda_low_d;
      if (data_wr) begin
        data_q <= data_in;
      end
      // a write in the same cycle as a load or flush still counts
      data_full_q <= data_wr | (data_full_q & ~load & ~flush);
      hide_q <= load | (hide_q & ~unhide);
      start_q <= start_set | (start_q & ~start_clr);
      stop_q <= stop_set | (stop_q & ~stop_clr);
      nack_q <= nack_set | (nack_q & ~nack_clr);
      if (ack_upd) begin
        ack_q <= ~sda_s;
      end
    end
  end

  // ==========================================
  // status and interrupts
  // empty while no byte is buffered and enabled; hidden during the first bit of a byte
  assign tx_empty_flag = block_on & ~data_full_q & ~hide_q;
  assign tx_irq = tx_irq_en & tx_empty_flag;
  assign nack_irq = block_on & nack_q;
  assign nack_flag = nack_q;
  assign ack_status = ack_q;
  assign start_pending = start_q;
  assign stop_pending = stop_q;
  assign busy = (state_q != S_IDLE);
  assign scl_out = 1'h0;
  assign sda_out = 1'h0;
  assign scl_oe = scl_low_q;
  assign sda_oe = sda_low_q;
endmodule
`default_nettype wire

// ---- pkg/i2c_seq_map.vh ----
// constants for the i2c master write and probe sequencer
`ifndef I2C_SEQ_MAP_VH
`define I2C_SEQ_MAP_VH

// ==========================================
// timing
`define CLK_NS 50
`define QTR_NS 100
// last count of a quarter: 100 ns at a 50 ns clock is two cycles
`define QTR_LAST 4'h1
`define QTR_W 4

// ==========================================
// quarter phases of one bit cell
`define PH_SETUP 2'h0
`define PH_LOW 2'h1
`define PH_RISE 2'h2
`define PH_HIGH 2'h3

// ==========================================
// byte shape
`define BIT_FIRST 3'h0
`define BIT_LAST 3'h7
`define BYTE_RST 8'h00

`endif

// ---- hw/bit_timer.v ----
// quarter-bit tick generator with clock stretch hold
`timescale 1ns/1ps
`default_nettype none
`include "i2c_seq_map.vh"
module bit_timer (
  input wire core_clk,
  input wire reset_n,
  input wire run,
  input wire stall,
  output wire tick
);
  localparam [`QTR_W-1:0] LAST = `QTR_LAST;
  reg [`QTR_W-1:0] cnt_q;

  assign tick = run & ~stall & (cnt_q == LAST);

  always @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= {`QTR_W{1'h0}};
    end else if (!run || tick) begin
      cnt_q <= {`QTR_W{1'h0}};
    end else if (!stall) begin
      cnt_q <= cnt_q + 1'h1;
    end
  end
endmodule
`default_nettype wire

// ---- tb/seq_checker_properties.sv ----
// assertion checker for the i2c write and probe sequencer
`timescale 1ns/1ps
`default_nettype none
module seq_checker (
  input wire core_clk,
  input wire reset_n,
  input wire block_on,
  input wire tx_irq_en,
  input wire data_wr,
  input wire start_pending,
  input wire stop_pending,
  input wire tx_empty_flag,
  input wire nack_flag,
  input wire ack_status,
  input wire tx_irq,
  input wire nack_irq,
  input wire busy,
  input wire scl_oe,
  input wire sda_oe
);
  // ==========================================
  // properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // margin of six cycles covers the one cycle that the registered clock pull lags the flag on entering the hold
  sequence nack_wait;
    (block_on && nack_flag && !stop_pending && !start_pending) [*6];
  endsequence
  chk_tx_irq_level: assert property (tx_irq == (tx_irq_en && tx_empty_flag))
    else $error("tx irq does not follow empty flag");
  chk_nack_irq_level: assert property (nack_irq == (block_on && nack_flag))
    else $error("nack irq does not follow nack flag");
  chk_write_clears_empty: assert property (data_wr |=> !tx_empty_flag)
    else $error("empty flag still set after data write");
  chk_busy_needs_start: assert property ($rose(busy) |-> $past(start_pending))
    else $error("sequencer left idle without start request");
  chk_start_while_high: assert property ($rose(sda_oe) && !scl_oe |-> start_pending)
    else $error("data pulled low with clock high outside start");
  chk_stop_clears_bits: assert property ($fell(stop_pending) |-> !nack_flag && !sda_oe)
    else $error("stop finished with nack flag or data low");
  chk_nack_no_pending: assert property ($rose(nack_flag) |->
    !$past(stop_pending) && !$past(start_pending) && !ack_status)
    else $error("nack flag set with request pending");
  chk_nack_holds_clock: assert property (nack_wait |-> scl_oe)
    else $error("clock not held low while nack waits");
endmodule
bind i2c_master_write_probe_seq seq_checker seq_checker_inst (.core_clk(core_clk),
  .reset_n(reset_n), .block_on(block_on), .tx_irq_en(tx_irq_en), .data_wr(data_wr),
  .start_pending(start_pending), .stop_pending(stop_pending), .tx_empty_flag(tx_empty_flag),
  .nack_flag(nack_flag), .ack_status(ack_status), .tx_irq(tx_irq), .nack_irq(nack_irq),
  .busy(busy), .scl_oe(scl_oe), .sda_oe(sda_oe));
`default_nettype wire

// ---- tb/i2c_slave_model.sv ----
// behavioural i2c slave that collects bytes and answers the ack slot
`timescale 1ns/1ps
`default_nettype none
module i2c_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic ack_en,
  output logic sda_low
);
  logic [7:0] sh;
  logic [7:0] got [$];
  int n;
  initial begin
    sda_low = 1'b0;
    n = 0;
    sh = 8'h00;
  end
  // ==========================================
  // framing
  always @(negedge sda) begin
    if (scl) n = 0;
  end
  always @(posedge scl) begin
    if (n < 8) sh = {sh[6:0], sda};
    n = n + 1;
    if (n == 8) got.push_back(sh);
  end
  // data only moves while clock is low, so no false start
  always @(negedge scl) begin
    sda_low = (n == 8) && ack_en;
    if (n == 9) n = 0;
  end
endmodule
`default_nettype wire

// ---- tb/i2c_master_write_probe_seq_bench.sv ----
// self-checking bench for the i2c write and probe sequencer
`timescale 1ns/1ps
`default_nettype none
module i2c_master_write_probe_seq_bench;
  logic core_clk, reset_n, block_on, tx_irq_en, start_set, stop_set, flush, data_wr;
  logic ack_en;
  logic [7:0] data_in, a, b, c;
  wire start_pending, stop_pending, tx_empty_flag, nack_flag, ack_status, tx_irq, nack_irq;
  wire busy, scl_out, scl_oe, sda_out, sda_oe, scl, sda, sda_low;
  int errors, compares;
  assign scl = !scl_oe;
  assign sda = !(sda_oe || sda_low);
  i2c_master_write_probe_seq i2c_master_write_probe_seq_inst (.core_clk(core_clk),
    .reset_n(reset_n), .block_on(block_on), .tx_irq_en(tx_irq_en), .start_set(start_set),
    .stop_set(stop_set), .flush(flush), .data_wr(data_wr), .data_in(data_in),
    .start_pending(start_pending), .stop_pending(stop_pending), .tx_empty_flag(tx_empty_flag),
    .nack_flag(nack_flag), .ack_status(ack_status), .tx_irq(tx_irq), .nack_irq(nack_irq),
    .busy(busy), .scl_in(scl), .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe));
  i2c_slave_model i2c_slave_model_inst (.scl(scl), .sda(sda), .ack_en(ack_en),
    .sda_low(sda_low));
  // ==========================================
  // helpers
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = !core_clk;
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  // p packs write, start, stop, flush pulses
  task put(input logic [3:0] p, input logic [7:0] d);
    {data_wr, start_set, stop_set, flush} = p;
    data_in = d;
    cyc(1);
    {data_wr, start_set, stop_set, flush} = 4'h0;
    cyc(1);
  endtask
  // kind 0 empty flag up, 1 stop cleared, 2 nack flag up; bounded
  task wait_until(input int kind);
    int i;
    i = 0;
    while (i < 4000 && ((kind == 0 && tx_empty_flag !== 1'b1) ||
      (kind == 1 && stop_pending !== 1'b0) || (kind == 2 && nack_flag !== 1'b1))) begin
      cyc(1);
      i++;
    end
    check({7'h00, i < 4000}, 8'h01);
  endtask
  function logic [7:0] last(input int back);
    return i2c_slave_model_inst.got[i2c_slave_model_inst.got.size() - 1 - back];
  endfunction
  function logic [7:0] ten_hi(input logic [1:0] x);
    return {5'h1E, x, 1'b0};
  endfunction
  initial begin
    #2000000;
    errors++;
    stop_test;
  end
  // ==========================================
  // scenarios
  initial begin
    {block_on, tx_irq_en, data_wr, start_set, stop_set, flush, ack_en} = 7'h00;
    data_in = 8'h00;
    reset_n = 1'b0;
    errors = 0;
    compares = 0;
    void'($urandom(32'h2dcd));
    cyc(12);
    reset_n = 1'b1;
    block_on = 1'b1;
    cyc(1);
    tx_irq_en = 1'b1;
    cyc(1);
    check({6'h00, tx_empty_flag, tx_irq}, 8'h03);
    a = {7'($urandom), 1'b0};
    for (int k = 0; k < 3; k++) begin
      ack_en = (k == 2);
      tx_irq_en = 1'b0;
      put(4'h8, a);
      put(4'h6, 8'h00);
      wait_until(1);
      check({6'h00, ack_status, nack_flag}, {6'h00, ack_en, 1'b0});
      check(last(0), a);
    end
    ack_en = 1'b1;
    tx_irq_en = 1'b1;
    b = 8'($urandom);
    c = {7'($urandom), 1'b0};
    put(4'h8, a);
    put(4'h4, 8'h00);
    wait_until(0);
    put(4'h8, b);
    wait_until(0);
    cyc(150);
    check({7'h00, scl}, 8'h00);
    put(4'hC, c);
    wait_until(0);
    tx_irq_en = 1'b0;
    put(4'h2, 8'h00);
    wait_until(1);
    check(last(2), a);
    check(last(1), b);
    check(last(0), c);
    check({7'h00, start_pending}, 8'h00);
    ack_en = 1'b0;
    tx_irq_en = 1'b1;
    put(4'h8, a);
    put(4'h4, 8'h00);
    wait_until(0);
    put(4'h8, b);
    wait_until(2);
    check({6'h00, ack_status, nack_irq}, 8'h01);
    tx_irq_en = 1'b0;
    put(4'h3, 8'h00);
    wait_until(1);
    tx_irq_en = 1'b1;
    cyc(1);
    check({6'h00, nack_flag, tx_irq}, 8'h01);
    ack_en = 1'b1;
    a = ten_hi(2'($urandom));
    put(4'h8, a);
    put(4'h4, 8'h00);
    wait_until(0);
    put(4'h8, b);
    wait_until(0);
    tx_irq_en = 1'b0;
    put(4'h2, 8'h00);
    wait_until(1);
    check(last(1), a);
    check(last(0), b);
    check({7'h00, ack_status}, 8'h01);
    // switching off mid-byte must release both lines together within two cycles
    put(4'h8, b);
    put(4'h4, 8'h00);
    wait_until(0);
    block_on = 1'b0;
    cyc(2);
    check({4'h0, busy, scl_oe, sda_oe, tx_irq}, 8'h00);
    check({6'h00, scl_out, sda_out}, 8'h00);
    stop_test;
  end
endmodule
`default_nettype wire
